// [tmr_timer_block.sv]
// Shared prescaler, first timer, watchdog and 16-bit second timer
`timescale 1ns/10ps
module tmr_timer_block #(
   parameter int WD_BASE_CYCLES = 1024
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic [7:0] s_axi_awaddr_in,
   output logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_wready_out,
   output logic s_axi_bvalid_out,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic [7:0] s_axi_araddr_in,
   output logic s_axi_arready_out,
   output logic s_axi_rvalid_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rready_in,
   input wire logic second_timer_ext_clock_pin_in,
   input wire logic special_trigger_in,
   output logic osc_enable_out,
   output logic watchdog_timeout_out
);
   logic [7:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;
   logic wr_fire;
   logic wr_ok;
   logic wr_option;
   logic wr_t1;
   logic wr_wd;
   logic wr_ctrl;
   logic wr_t2lo;
   logic wr_t2hi;
   logic wr_status;
   logic rd_ok;
   logic [7:0] rd_byte;

   tmr_pkg::tmr_option_t option_q;
   tmr_pkg::tmr_ctrl_t ctrl_q;
   tmr_pkg::tmr_status_t status_q;
   logic [7:0] first_timer_count_q;
   logic [15:0] second_timer_q;
   logic [1:0] instr_div_q;
   logic instr_tick;

   logic [31:0] wd_base_q;
   logic wd_base_tick;
   logic [7:0] watchdog_counter_q;
   logic wd_overflow;
   logic wd_clear;

   logic pre_tick_in;
   logic pre_clear;
   logic [3:0] pre_shift;
   logic pre_tick_out;
   logic t1_tick;
   logic wd_expire;

   logic ext_meta_q;
   logic ext_sync_q;
   logic ext_prev_q;
   logic ext_rise;
   logic ext_pend_q;
   logic t2_src_tick;
   logic [2:0] t2_pre_q;
   logic [2:0] t2_pre_last;
   logic t2_inc;

   // Write address and data are taken in either order
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_awready_out <= 1'b1;
         aw_addr_q <= tmr_pkg::BYTE_ZERO;
      end else if (s_axi_awvalid_in && s_axi_awready_out) begin
         s_axi_awready_out <= 1'b0;
         aw_addr_q <= s_axi_awaddr_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_awready_out <= 1'b1;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_wready_out <= 1'b1;
         w_data_q <= tmr_pkg::BYTE_ZERO;
         w_lane0_q <= 1'b0;
      end else if (s_axi_wvalid_in && s_axi_wready_out) begin
         s_axi_wready_out <= 1'b0;
         w_data_q <= s_axi_wdata_in[7:0];
         w_lane0_q <= s_axi_wstrb_in[0];
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_wready_out <= 1'b1;
      end
   end

   // Write decode; only byte lane 0 carries register data
   always_comb begin
      wr_fire = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
      wr_ok = 1'b1;
      wr_option = 1'b0;
      wr_t1 = 1'b0;
      wr_wd = 1'b0;
      wr_ctrl = 1'b0;
      wr_t2lo = 1'b0;
      wr_t2hi = 1'b0;
      wr_status = 1'b0;
      unique case (aw_addr_q)
         tmr_pkg::OFF_OPTION: wr_option = wr_fire & w_lane0_q;
         tmr_pkg::OFF_T1_COUNT: wr_t1 = wr_fire & w_lane0_q;
         tmr_pkg::OFF_WD_CLEAR: wr_wd = wr_fire & w_lane0_q;
         tmr_pkg::OFF_T2_CTRL: wr_ctrl = wr_fire & w_lane0_q;
         tmr_pkg::OFF_T2_LOW: wr_t2lo = wr_fire & w_lane0_q;
         tmr_pkg::OFF_T2_HIGH: wr_t2hi = wr_fire & w_lane0_q;
         tmr_pkg::OFF_STATUS: wr_status = wr_fire & w_lane0_q;
         default: wr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= tmr_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out <= wr_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // Read decode; prescaler count has no address
   always_comb begin
      rd_ok = 1'b1;
      rd_byte = tmr_pkg::BYTE_ZERO;
      unique case (s_axi_araddr_in)
         tmr_pkg::OFF_OPTION: rd_byte = {4'h0, option_q};
         tmr_pkg::OFF_T1_COUNT: rd_byte = first_timer_count_q;
         tmr_pkg::OFF_WD_CLEAR: rd_byte = tmr_pkg::BYTE_ZERO;
         tmr_pkg::OFF_T2_CTRL: rd_byte = {2'h0, ctrl_q};
         tmr_pkg::OFF_T2_LOW: rd_byte = second_timer_q[7:0];
         tmr_pkg::OFF_T2_HIGH: rd_byte = second_timer_q[15:8];
         tmr_pkg::OFF_STATUS: rd_byte = {5'h00, status_q};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0000_0000;
         s_axi_rresp_out <= tmr_pkg::RESP_OKAY;
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= {24'h000000, rd_byte};
         s_axi_rresp_out <= rd_ok ? tmr_pkg::RESP_OKAY : tmr_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
      end
   end

   // Configuration registers
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         option_q <= tmr_pkg::OPTION_RESET;
      end else if (wr_option) begin
         option_q <= w_data_q[3:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_q <= tmr_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= w_data_q[5:0];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         osc_enable_out <= 1'b0;
      end else begin
         osc_enable_out <= ctrl_q.osc_enable;
      end
   end

   // Instruction clock tick, one core cycle in four
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         instr_div_q <= 2'h0;
      end else begin
         instr_div_q <= instr_div_q + 2'h1;
      end
   end
   assign instr_tick = (instr_div_q == tmr_pkg::INSTR_LAST);

   // Watchdog base time and 8-bit watchdog counter
   assign wd_clear = wr_wd & w_data_q[tmr_pkg::WD_CLEAR_BIT];
   assign wd_base_tick = (wd_base_q == 32'(WD_BASE_CYCLES - 1));

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wd_base_q <= 32'h0000_0000;
      end else if (wd_clear || wd_base_tick) begin
         wd_base_q <= 32'h0000_0000;
      end else begin
         wd_base_q <= wd_base_q + 32'h0000_0001;
      end
   end

   assign wd_overflow = wd_base_tick &
      (watchdog_counter_q == tmr_pkg::WD_ALL_ONES) & ~wd_clear;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         watchdog_counter_q <= tmr_pkg::BYTE_ZERO;
      end else if (wd_clear) begin
         watchdog_counter_q <= tmr_pkg::BYTE_ZERO;
      end else if (wd_base_tick) begin
         watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
   end

   // Prescaler routing by owner
   always_comb begin
      if (option_q.owner_wd) begin
         pre_tick_in = wd_overflow;
         pre_clear = wd_clear;
         pre_shift = {1'b0, option_q.ratio};
      end else begin
         pre_tick_in = instr_tick;
         pre_clear = wr_t1;
         pre_shift = 4'({1'b0, option_q.ratio} + 4'h1);
      end
   end

   tmr_shared_prescaler u_prescaler (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .tick_in(pre_tick_in),
      .clear_in(pre_clear),
      .shift_in(pre_shift),
      .tick_out(pre_tick_out)
   );

   assign t1_tick = option_q.owner_wd ? instr_tick : pre_tick_out;
   assign wd_expire = option_q.owner_wd ? pre_tick_out : wd_overflow;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         watchdog_timeout_out <= 1'b0;
      end else begin
         watchdog_timeout_out <= wd_expire;
      end
   end

   // First timer count
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         first_timer_count_q <= tmr_pkg::BYTE_ZERO;
      end else if (wr_t1) begin
         first_timer_count_q <= w_data_q;
      end else if (t1_tick) begin
         first_timer_count_q <= first_timer_count_q + 8'h01;
      end
   end

   // External pin synchroniser and rise detect
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= second_timer_ext_clock_pin_in;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end
   assign ext_rise = ext_sync_q & ~ext_prev_q;

   // Synchronised mode holds a rise until the next instruction tick
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ext_pend_q <= 1'b0;
      end else if (instr_tick) begin
         ext_pend_q <= 1'b0;
      end else if (ext_rise) begin
         ext_pend_q <= 1'b1;
      end
   end

   always_comb begin
      if (!ctrl_q.clock_source) begin
         t2_src_tick = instr_tick;
      end else if (ctrl_q.sync_bypass) begin
         t2_src_tick = ext_rise;
      end else begin
         t2_src_tick = instr_tick & (ext_pend_q | ext_rise);
      end
   end

   // Second timer input prescale 1, 2, 4 or 8
   assign t2_pre_last = 3'(4'(4'h1 << ctrl_q.prescale_sel) - 4'h1);
   assign t2_inc = ctrl_q.run & t2_src_tick &
      (t2_pre_q >= t2_pre_last);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         t2_pre_q <= 3'h0;
      end else if (ctrl_q.run && t2_src_tick) begin
         if (t2_pre_q >= t2_pre_last) begin
            t2_pre_q <= 3'h0;
         end else begin
            t2_pre_q <= t2_pre_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         second_timer_q <= 16'h0000;
      end else if (special_trigger_in) begin
         second_timer_q <= 16'h0000;
      end else if (wr_t2lo) begin
         second_timer_q[7:0] <= w_data_q;
      end else if (wr_t2hi) begin
         second_timer_q[15:8] <= w_data_q;
      end else if (t2_inc) begin
         second_timer_q <= second_timer_q + 16'h0001;
      end
   end

   // Sticky flags, write one to clear, a new event wins
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         status_q <= 3'h0;
      end else begin
         status_q.t2_overflow <= (status_q.t2_overflow &
            ~(wr_status & w_data_q[0])) |
            (t2_inc & ~special_trigger_in & ~wr_t2lo & ~wr_t2hi &
            (second_timer_q == tmr_pkg::T2_ALL_ONES));
         status_q.t1_overflow <= (status_q.t1_overflow &
            ~(wr_status & w_data_q[1])) |
            (t1_tick & ~wr_t1 &
            (first_timer_count_q == tmr_pkg::T1_ALL_ONES));
         status_q.wd_timeout <= (status_q.wd_timeout &
            ~(wr_status & w_data_q[2])) | wd_expire;
      end
   end
endmodule

// [tmr_pkg.sv]
// Shared constants and types for the timer block
package tmr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_OPTION = 8'h00;
   localparam logic [7:0] OFF_T1_COUNT = 8'h04;
   localparam logic [7:0] OFF_WD_CLEAR = 8'h08;
   localparam logic [7:0] OFF_T2_CTRL = 8'h10;
   localparam logic [7:0] OFF_T2_LOW = 8'h14;
   localparam logic [7:0] OFF_T2_HIGH = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;

   // Option configuration: owner bit over the ratio field
   typedef struct packed {
      logic owner_wd;
      logic [2:0] ratio;
   } tmr_option_t;

   // Second timer control, bits 5:0
   typedef struct packed {
      logic [1:0] prescale_sel;
      logic osc_enable;
      logic sync_bypass;
      logic clock_source;
      logic run;
   } tmr_ctrl_t;

   // Sticky event flags
   typedef struct packed {
      logic wd_timeout;
      logic t1_overflow;
      logic t2_overflow;
   } tmr_status_t;

   localparam tmr_option_t OPTION_RESET = 4'hf;
   localparam tmr_ctrl_t CTRL_RESET = 6'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [15:0] T2_ALL_ONES = 16'hffff;
   localparam logic [7:0] T1_ALL_ONES = 8'hff;
   localparam logic [7:0] WD_ALL_ONES = 8'hff;
   localparam int WD_CLEAR_BIT = 0;

   // Instruction clock is the core clock divided by four
   localparam logic [1:0] INSTR_LAST = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [tmr_shared_prescaler.sv]
// Shared 8-bit prescaler with power-of-two ratio
`timescale 1ns/10ps
module tmr_shared_prescaler (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic clear_in,
   input wire logic [3:0] shift_in,
   output logic tick_out
);
   logic [7:0] count_q;
   logic [8:0] span;
   logic [7:0] last;

   // Terminal count is two to the shift, minus one
   always_comb begin
      span = 9'h001 << shift_in;
      last = 8'(span - 9'h001);
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_q <= 8'h00;
      end else if (clear_in) begin
         count_q <= 8'h00;
      end else if (tick_in) begin
         // A count left above a lowered ratio wraps at once
         if (count_q >= last) begin
            count_q <= 8'h00;
         end else begin
            count_q <= count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         tick_out <= 1'b0;
      end else begin
         tick_out <= tick_in & ~clear_in & (count_q >= last);
      end
   end
endmodule

// [tmr_ext_clock_source.sv]
// External clock source model for the second timer's pin
`timescale 1ns/10ps
module tmr_ext_clock_source (
   output logic pin_out
);
   initial pin_out = 1'b0;
   // Bursts of rising edges; the pin rests low between bursts
   task automatic pulses(input int count, input int half_ns);
      repeat (count) begin
         #(half_ns) pin_out = 1'b1;
         #(half_ns) pin_out = 1'b0;
      end
   endtask
endmodule

// [tmr_timer_block_sva.sv]
// Port assertions for the timer block
`timescale 1ns/10ps
module tmr_timer_block_sva (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic s_axi_awvalid_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awready_out,
   input wire logic s_axi_wvalid_in,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wready_out,
   input wire logic s_axi_bvalid_out,
   input wire logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   input wire logic [31:0] s_axi_rdata_out,
   input wire logic [1:0] s_axi_rresp_out,
   input wire logic s_axi_rready_in,
   input wire logic osc_enable_out,
   input wire logic watchdog_timeout_out
);
   logic [7:0] rd_addr_q;
   logic [7:0] wr_addr_q;
   logic [1:0] wr_bits_q;
   logic rd_mapped;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) rd_addr_q <= 8'h00;
      else if (s_axi_arvalid_in && s_axi_arready_out) rd_addr_q <= s_axi_araddr_in;
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) wr_addr_q <= 8'h00;
      else if (s_axi_awvalid_in && s_axi_awready_out) wr_addr_q <= s_axi_awaddr_in;
   end
   // Lane 0 strobe beside control bit 3
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) wr_bits_q <= 2'h0;
      else if (s_axi_wvalid_in && s_axi_wready_out)
         wr_bits_q <= {s_axi_wstrb_in[0], s_axi_wdata_in[3]};
   end
   assign rd_mapped = rd_addr_q inside
      {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1c};
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   property p_b_answer;
      s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in &&
      s_axi_wready_out |-> ##[1:3] s_axi_bvalid_out;
   endproperty
   a_b_answer: assert property (p_b_answer)
      else $error("write response missing");
   property p_b_hold;
      s_axi_bvalid_out && !s_axi_bready_in |=>
      s_axi_bvalid_out && $stable(s_axi_bresp_out);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped early");
   property p_r_hold;
      s_axi_rvalid_out && !s_axi_rready_in |=>
      s_axi_rvalid_out && $stable(s_axi_rdata_out);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped early");
   property p_r_upper;
      s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0 && !s_axi_arready_out;
   endproperty
   a_r_upper: assert property (p_r_upper)
      else $error("read upper bits or ready wrong");
   property p_ctrl_top;
      s_axi_rvalid_out && rd_addr_q == 8'h10 |-> s_axi_rdata_out[7:6] == 2'h0;
   endproperty
   a_ctrl_top: assert property (p_ctrl_top)
      else $error("control top bits not zero");
   property p_unmapped;
      s_axi_rvalid_out && !rd_mapped |->
      s_axi_rresp_out == 2'h2 && s_axi_rdata_out == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not refused");
   property p_osc;
      $rose(s_axi_bvalid_out) && wr_addr_q == 8'h10 && wr_bits_q[1] |->
      ##[0:2] osc_enable_out == wr_bits_q[0];
   endproperty
   a_osc: assert property (p_osc)
      else $error("oscillator enable does not follow control");
   property p_osc_cause;
      $changed(osc_enable_out) |-> $past(s_axi_bvalid_out);
   endproperty
   a_osc_cause: assert property (p_osc_cause)
      else $error("oscillator enable changed without write");
   property p_readies;
      s_axi_bvalid_out && s_axi_bready_in |=> s_axi_awready_out && s_axi_wready_out;
   endproperty
   a_readies: assert property (p_readies)
      else $error("write readies not restored");
   property p_wd_pulse;
      watchdog_timeout_out |=> !watchdog_timeout_out;
   endproperty
   a_wd_pulse: assert property (p_wd_pulse)
      else $error("watchdog timeout longer than one cycle");
endmodule
bind tmr_timer_block tmr_timer_block_sva tmr_timer_block_sva_i (.*);

// [tmr_timer_block_bench.sv]
// Self-checking bench for the timer block
`timescale 1ns/10ps
module tmr_timer_block_bench;
   typedef struct packed {
      logic [7:0] a;
      logic [7:0] d;
      logic [7:0] e;
      logic [1:0] r;
   } tmr_row_t;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0;
   logic s_axi_bready_in = 1'b0, s_axi_arvalid_in = 1'b0;
   logic s_axi_rready_in = 1'b0, special_trigger_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
   logic s_axi_arready_out, s_axi_rvalid_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
   logic [31:0] s_axi_rdata_out, rd;
   logic second_timer_ext_clock_pin_in, osc_enable_out, watchdog_timeout_out;
   int fail_count = 0, checked = 0, cycles = 0, n, e;
   tmr_row_t rows [8] = '{'{8'h00, 8'h05, 8'h05, 2'h0},
      '{8'h10, 8'hff, 8'h3f, 2'h0}, '{8'h10, 8'h00, 8'h00, 2'h0},
      '{8'h08, 8'h01, 8'h00, 2'h0}, '{8'h20, 8'h5a, 8'h00, 2'h2},
      '{8'h04, 8'h77, 8'h77, 2'h0}, '{8'h14, 8'h34, 8'h34, 2'h0},
      '{8'h18, 8'h12, 8'h12, 2'h0}};
   tmr_timer_block #(.WD_BASE_CYCLES(4)) tmr_timer_block_i (.*);
   tmr_ext_clock_source tmr_ext_clock_source_i (
      .pin_out(second_timer_ext_clock_pin_in));
   always #4 clk_in = ~clk_in;
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] x);
      checked++;
      if (g !== x) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= {24'h0, d};
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_bvalid_out !== 1'b1);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
         @(posedge clk_in);
         if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_rvalid_out !== 1'b1);
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
      rdr(a);
      chk(rd, {24'h0, x});
   endtask
   // Range check on a count read back
   task automatic near(input logic [7:0] a, input int lo, input int hi);
      rdr(a);
      chk({31'h0, rd >= lo && rd <= hi}, 32'h1);
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         chk({30'h0, rs}, {30'h0, rows[i].r});
         rdr(rows[i].a);
         chk({30'h0, rs}, {30'h0, rows[i].r});
         chk(rd, {24'h0, rows[i].e});
      end
      $display("register rows done");
      @(posedge clk_in);
      rst_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rst_in <= 1'b0;
      rdchk(8'h10, 8'h00);
      rdchk(8'h14, 8'h00);
      wr(8'h14, 8'h34);
      @(posedge clk_in);
      special_trigger_in <= 1'b1;
      @(posedge clk_in);
      special_trigger_in <= 1'b0;
      rdchk(8'h14, 8'h00);
      $display("reset and trigger done");
      for (int p = 0; p < 4; p++) begin
         wr(8'h14, 8'h00);
         wr(8'h10, {2'h0, p[1:0], 4'h1});
         repeat (800) @(posedge clk_in);
         wr(8'h10, 8'h00);
         e = 200 >> p;
         near(8'h14, e - 1, e + 2);
      end
      n = rd;
      repeat (50) @(posedge clk_in);
      rdchk(8'h14, n[7:0]);
      wr(8'h1c, 8'h07);
      wr(8'h14, 8'hfe);
      wr(8'h18, 8'hff);
      wr(8'h10, 8'h01);
      repeat (20) @(posedge clk_in);
      wr(8'h10, 8'h00);
      rdr(8'h1c);
      chk(rd & 32'h1, 32'h1);
      rdchk(8'h18, 8'h00);
      $display("internal counting done");
      wr(8'h14, 8'h00);
      wr(8'h10, 8'h03);
      tmr_ext_clock_source_i.pulses(10, 44);
      repeat (10) @(posedge clk_in);
      rdchk(8'h14, 8'h0a);
      wr(8'h10, 8'h0f);
      tmr_ext_clock_source_i.pulses(10, 44);
      repeat (10) @(posedge clk_in);
      rdchk(8'h14, 8'h14);
      chk({31'h0, osc_enable_out}, 32'h1);
      wr(8'h10, 8'h00);
      repeat (3) @(posedge clk_in);
      chk({31'h0, osc_enable_out}, 32'h0);
      $display("external counting done");
      wr(8'h00, 8'h00);
      wr(8'h04, 8'h00);
      repeat (400) @(posedge clk_in);
      near(8'h04, 49, 52);
      rdchk(8'h00, 8'h00);
      wr(8'h00, 8'h08);
      wr(8'h04, 8'h00);
      rdchk(8'h00, 8'h08);
      repeat (40) @(posedge clk_in);
      near(8'h04, 10, 14);
      for (int k = 0; k < 3; k++) begin
         wr(8'h00, k == 2 ? 8'h00 : 8'h08 + k[7:0]);
         wr(8'h08, 8'h01);
         n = 0;
         while (watchdog_timeout_out !== 1'b1 && n < 3000) begin
            @(posedge clk_in);
            n++;
         end
         e = k == 1 ? 2048 : 1024;
         chk({31'h0, n >= e - 8 && n <= e + 8}, 32'h1);
      end
      $display("watchdog done");
      complete_run();
   end
endmodule
